// >>> lv_pkg.sv
// Package for the low-voltage detect status and control block.
// Assumes a single clock domain and an AXI4-Lite register slave.
package lv_pkg;

   // ************************************************************
   // Register map
   // ************************************************************
   localparam logic [15:0] status_control_addr = 16'h3040;
   localparam logic [15:0] irq_status_addr     = 16'h3044;
   localparam logic [15:0] irq_mask_addr       = 16'h3048;
   localparam logic [15:0] line_status_addr    = 16'h304c;

   // ************************************************************
   // Field positions of the status and control register
   // ************************************************************
   localparam int warning_flag_bit     = 7;
   localparam int warning_ack_bit      = 6;
   localparam int warning_irq_en_bit   = 5;
   localparam int detect_reset_en_bit  = 4;
   localparam int detect_stop_en_bit   = 3;
   localparam int detect_en_bit        = 2;

   // ************************************************************
   // Reset values
   // ************************************************************
   localparam logic [7:0] status_control_reset = 8'h1c;
   localparam logic [1:0] irq_mask_reset       = 2'h0;

   // ************************************************************
   // Event bits of the interrupt status and mask registers
   // ************************************************************
   localparam int evt_warning_bit = 0;
   localparam int evt_detect_bit  = 1;
   localparam int evt_count       = 2;

   // ************************************************************
   // AXI responses
   // ************************************************************
   localparam logic [1:0] resp_okay   = 2'h0;
   localparam logic [1:0] resp_slverr = 2'h2;

endpackage

// >>> lv_sync.sv
// Two-flop synchroniser for a group of asynchronous level inputs.
// Assumes the inputs are quasi-static compared with the clock.
`timescale 1ns/100ps
module lv_sync #(
   parameter int width = 1
) (
   // Clock and reset.
   input  wire logic             aclk,
   input  wire logic             aresetn,
   // Asynchronous levels in, synchronised levels out.
   input  wire logic [width-1:0] async_in,
   output logic      [width-1:0] sync_out
);

   logic [width-1:0] meta_reg;
   logic [width-1:0] meta_next;
   logic [width-1:0] sync_reg;
   logic [width-1:0] sync_next;

   initial begin
      if (width < 1) $error("lv_sync width must be at least one");
   end

   // The first stage is read by the second stage only.
   always_comb begin
      meta_next = async_in;
      sync_next = meta_reg;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta_reg <= '0;
         sync_reg <= '0;
      end else begin
         meta_reg <= meta_next;
         sync_reg <= sync_next;
      end
   end

   assign sync_out = sync_reg;

endmodule

// >>> lv_detect_control.sv
// Low-voltage detect status and control register bank with AXI4-Lite slave.
// Assumes the analog comparator levels and stop/debug levels are asynchronous.
//
// What this block does
// - Set warning flag on supply falling below warning trip, also right after reset.
// - Warning flag reads one while warning present or held since last clear.
// - Writing one to bit 6 clears the flag only if warning gone.
// - Bit 5 set requests an interrupt whenever the warning flag is one.
// - Bit 4 with detect enabled makes a detect event force a reset.
// - Detect reset enable takes only the first write after each reset.
// - Bit 3 keeps detection running in stop mode; zero disables it there unless debug enable is set.
// - Bit 2 turns detection on and qualifies bits 3 and 4; bit 5 and the warning flag work without it.
// - Detect enable is writable once after reset; later writes ignored.
// - The register decodes at address 3040h.
// - Entering stop disables detection unless stop enable or debug enable set.
// - The register resets to 1Ch, eight bits wide, read and write.
`timescale 1ns/100ps
module lv_detect_control (
   // Clock and reset.
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // AXI4-Lite write address channel.
   input  wire logic [15:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   // AXI4-Lite write data channel.
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   // AXI4-Lite write response channel.
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // AXI4-Lite read address channel.
   input  wire logic [15:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   // AXI4-Lite read data channel.
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Analog comparator and power-mode levels, asynchronous.
   input  wire logic        low_voltage_warning,
   input  wire logic        low_voltage_detect,
   input  wire logic        stop_mode,
   input  wire logic        debug_mode_enable,
   // Outputs to the power and reset logic.
   output logic             detect_active,
   output logic             detect_reset_req,
   output logic             irq
);

   // ************************************************************
   // Input synchronisers
   // ************************************************************
   logic [3:0] sync_levels;
   logic       warn_s;
   logic       detect_s;
   logic       stop_s;
   logic       debug_s;

   lv_sync #(.width(4)) u_sync (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .async_in ({debug_mode_enable, stop_mode, low_voltage_detect, low_voltage_warning}),
      .sync_out (sync_levels)
   );

   assign warn_s   = sync_levels[0];
   assign detect_s = sync_levels[1];
   assign stop_s   = sync_levels[2];
   assign debug_s  = sync_levels[3];

   // ************************************************************
   // State
   // ************************************************************
   typedef enum logic [1:0] {idle_w, wresp_w} wstate_t;
   typedef enum logic [1:0] {idle_r, rdata_r} rstate_t;

   wstate_t    wstate_reg, wstate_next;
   rstate_t    rstate_reg, rstate_next;
   logic       aw_held_reg, aw_held_next;
   logic       w_held_reg, w_held_next;
   logic [15:0] awaddr_reg, awaddr_next;
   logic [31:0] wdata_reg, wdata_next;
   logic       wstrb0_reg, wstrb0_next;
   logic [1:0] bresp_reg, bresp_next;
   logic [31:0] rdata_reg, rdata_next;
   logic [1:0] rresp_reg, rresp_next;

   logic       flag_reg, flag_next;
   logic       irq_en_reg, irq_en_next;
   logic       rst_en_reg, rst_en_next;
   logic       stop_en_reg, stop_en_next;
   logic       det_en_reg, det_en_next;
   logic       once_done_reg, once_done_next;
   logic       warn_prev_reg, warn_prev_next;
   logic       det_prev_reg, det_prev_next;
   logic [1:0] evt_sts_reg, evt_sts_next;
   logic [1:0] evt_mask_reg, evt_mask_next;
   logic       active_reg, active_next;
   logic       rstreq_reg, rstreq_next;
   logic       irq_reg, irq_next;

   logic       do_write;
   logic       wr_ctrl;
   logic       detect_on;
   logic [1:0] evt_set;
   logic [7:0] ctrl_view;

   // ************************************************************
   // Detection qualification
   // ************************************************************
   // Detection runs when enabled, and in stop only if stop enable or debug keeps it.
   assign detect_on = det_en_reg && (!stop_s || stop_en_reg || debug_s);

   // Acknowledge and bits 1 to 0 read back as zero; bits 7 and 5 to 2 reflect state.
   assign ctrl_view = {flag_reg, 1'b0, irq_en_reg, rst_en_reg, stop_en_reg, det_en_reg,
                       2'b00};

   assign do_write = (wstate_reg == idle_w) && (wstate_next == wresp_w); // Holders clear here.
   assign wr_ctrl  = do_write && wstrb0_next
                     && (awaddr_next[15:2] == lv_pkg::status_control_addr[15:2]);

   // Rising edges of the synchronised comparator levels are the events; a detect edge counts only while detection is on.
   assign evt_set[lv_pkg::evt_warning_bit] = warn_s && !warn_prev_reg;
   assign evt_set[lv_pkg::evt_detect_bit]  = detect_s && !det_prev_reg && detect_on;

   // ************************************************************
   // Write channel
   // ************************************************************
   // Address and data are captured in either order; the response follows both.
   always_comb begin
      aw_held_next = aw_held_reg;
      w_held_next  = w_held_reg;
      awaddr_next  = awaddr_reg;
      wdata_next   = wdata_reg;
      wstrb0_next  = wstrb0_reg;
      wstate_next  = wstate_reg;
      bresp_next   = bresp_reg;
      if (s_axi_awvalid && s_axi_awready) begin
         aw_held_next = 1'b1;
         awaddr_next  = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         w_held_next = 1'b1;
         wdata_next  = s_axi_wdata;
         wstrb0_next = s_axi_wstrb[0];
      end
      unique case (wstate_reg)
         idle_w: begin
            if (aw_held_next && w_held_next) begin
               wstate_next  = wresp_w;
               aw_held_next = 1'b0;
               w_held_next  = 1'b0;
               bresp_next   = lv_pkg::resp_okay;
               if (awaddr_next[15:2] != lv_pkg::status_control_addr[15:2]
                   && awaddr_next[15:2] != lv_pkg::irq_status_addr[15:2]
                   && awaddr_next[15:2] != lv_pkg::irq_mask_addr[15:2]
                   && awaddr_next[15:2] != lv_pkg::line_status_addr[15:2]) begin
                  bresp_next = lv_pkg::resp_slverr;
               end
            end
         end
         wresp_w: begin
            if (s_axi_bready) wstate_next = idle_w;
         end
      endcase
   end

   // ************************************************************
   // Control register
   // ************************************************************
   // A new warning edge wins over an acknowledge in the same cycle.
   always_comb begin
      flag_next      = flag_reg;
      irq_en_next    = irq_en_reg;
      rst_en_next    = rst_en_reg;
      stop_en_next   = stop_en_reg;
      det_en_next    = det_en_reg;
      once_done_next = once_done_reg;
      if (wr_ctrl) begin
         if (wdata_next[lv_pkg::warning_ack_bit] && !warn_s) begin
            flag_next = 1'b0;
         end
         irq_en_next  = wdata_next[lv_pkg::warning_irq_en_bit];
         stop_en_next = wdata_next[lv_pkg::detect_stop_en_bit];
         if (!once_done_reg) begin
            rst_en_next    = wdata_next[lv_pkg::detect_reset_en_bit];
            det_en_next    = wdata_next[lv_pkg::detect_en_bit];
            once_done_next = 1'b1;
         end
      end
      // Level held high after reset also sets the flag, as does any new edge.
      if (warn_s) flag_next = 1'b1;
   end

   // ************************************************************
   // Interrupt status, mask and outputs
   // ************************************************************
   always_comb begin
      evt_sts_next   = evt_sts_reg;
      evt_mask_next  = evt_mask_reg;
      warn_prev_next = warn_s;
      det_prev_next  = detect_s;
      if (do_write && wstrb0_next) begin
         if (awaddr_next[15:2] == lv_pkg::irq_status_addr[15:2]) begin
            evt_sts_next = evt_sts_reg & ~wdata_next[1:0];
         end
         if (awaddr_next[15:2] == lv_pkg::irq_mask_addr[15:2]) begin
            evt_mask_next = wdata_next[1:0];
         end
      end
      // Set wins over a write-one clear.
      evt_sts_next = evt_sts_next | evt_set;
      active_next  = detect_on;
      rstreq_next  = detect_on && rst_en_reg && detect_s;
      // Level request tracks the flag and enable combined with the status bits.
      irq_next = (irq_en_next && flag_next) || |(evt_sts_next & evt_mask_next);
   end

   // ************************************************************
   // Read channel
   // ************************************************************
   always_comb begin
      rstate_next = rstate_reg;
      rdata_next  = rdata_reg;
      rresp_next  = rresp_reg;
      unique case (rstate_reg)
         idle_r: begin
            if (s_axi_arvalid && s_axi_arready) begin
               rstate_next = rdata_r;
               rresp_next  = lv_pkg::resp_okay;
               rdata_next  = 32'h0000_0000;
               unique case (s_axi_araddr[15:2])
                  lv_pkg::status_control_addr[15:2]: rdata_next[7:0] = ctrl_view;
                  lv_pkg::irq_status_addr[15:2]:     rdata_next[1:0] = evt_sts_reg;
                  lv_pkg::irq_mask_addr[15:2]:       rdata_next[1:0] = evt_mask_reg;
                  lv_pkg::line_status_addr[15:2]:    rdata_next[3:0] = sync_levels;
                  default:                           rresp_next = lv_pkg::resp_slverr;
               endcase
            end
         end
         rdata_r: begin
            if (s_axi_rready) rstate_next = idle_r;
         end
      endcase
   end

   // ************************************************************
   // Registers
   // ************************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wstate_reg    <= idle_w;
         rstate_reg    <= idle_r;
         aw_held_reg   <= 1'b0;
         w_held_reg    <= 1'b0;
         awaddr_reg    <= 16'h0000;
         wdata_reg     <= 32'h0000_0000;
         wstrb0_reg    <= 1'b0;
         bresp_reg     <= lv_pkg::resp_okay;
         rdata_reg     <= 32'h0000_0000;
         rresp_reg     <= lv_pkg::resp_okay;
         // Reset image of the control register.
         flag_reg      <= lv_pkg::status_control_reset[lv_pkg::warning_flag_bit];
         irq_en_reg    <= lv_pkg::status_control_reset[lv_pkg::warning_irq_en_bit];
         rst_en_reg    <= lv_pkg::status_control_reset[lv_pkg::detect_reset_en_bit];
         stop_en_reg   <= lv_pkg::status_control_reset[lv_pkg::detect_stop_en_bit];
         det_en_reg    <= lv_pkg::status_control_reset[lv_pkg::detect_en_bit];
         once_done_reg <= 1'b0;
         warn_prev_reg <= 1'b0;
         det_prev_reg  <= 1'b0;
         evt_sts_reg   <= 2'h0;
         evt_mask_reg  <= lv_pkg::irq_mask_reset;
         active_reg    <= 1'b0;
         rstreq_reg    <= 1'b0;
         irq_reg       <= 1'b0;
      end else begin
         wstate_reg    <= wstate_next;
         rstate_reg    <= rstate_next;
         aw_held_reg   <= aw_held_next;
         w_held_reg    <= w_held_next;
         awaddr_reg    <= awaddr_next;
         wdata_reg     <= wdata_next;
         wstrb0_reg    <= wstrb0_next;
         bresp_reg     <= bresp_next;
         rdata_reg     <= rdata_next;
         rresp_reg     <= rresp_next;
         flag_reg      <= flag_next;
         irq_en_reg    <= irq_en_next;
         rst_en_reg    <= rst_en_next;
         stop_en_reg   <= stop_en_next;
         det_en_reg    <= det_en_next;
         once_done_reg <= once_done_next;
         warn_prev_reg <= warn_prev_next;
         det_prev_reg  <= det_prev_next;
         evt_sts_reg   <= evt_sts_next;
         evt_mask_reg  <= evt_mask_next;
         active_reg    <= active_next;
         rstreq_reg    <= rstreq_next;
         irq_reg       <= irq_next;
      end
   end

   // ************************************************************
   // Output ports
   // ************************************************************
   // Write ready flags are registered holders inverted; arready follows the read state; each is a flop output.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
      end else begin
         s_axi_awready <= !aw_held_next && (wstate_next == idle_w)
                          && !(s_axi_awvalid && s_axi_awready);
         s_axi_wready  <= !w_held_next && (wstate_next == idle_w)
                          && !(s_axi_wvalid && s_axi_wready);
         s_axi_bvalid  <= (wstate_next == wresp_w);
         s_axi_arready <= (rstate_next == idle_r);
         s_axi_rvalid  <= (rstate_next == rdata_r);
      end
   end

   assign s_axi_bresp      = bresp_reg;
   assign s_axi_rdata      = rdata_reg;
   assign s_axi_rresp      = rresp_reg;
   assign detect_active    = active_reg;
   assign detect_reset_req = rstreq_reg;
   assign irq              = irq_reg;

endmodule

// >>> lv_detect_control_properties.sv
// Concurrent checks for the low-voltage detect register block.
// Assumes it is bound to lv_detect_control and sees only its ports.
`timescale 1ns/100ps
module lv_detect_control_properties (
   // Clock and reset.
   input wire logic        aclk,
   input wire logic        aresetn,
   // Register bus.
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [15:0] s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   // Comparator levels and power outputs.
   input wire logic        low_voltage_warning,
   input wire logic        low_voltage_detect,
   input wire logic        detect_active,
   input wire logic        detect_reset_req
);
   // ****************************************************
   // Clocking
   // ****************************************************
   // One clock domain, so one default clock and reset serve every check.
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   // A read taken at the control word's address.
   sequence s_ctl_read;
      s_axi_arvalid && s_axi_arready && s_axi_araddr == lv_pkg::status_control_addr;
   endsequence

   // ****************************************************
   // Properties
   // ****************************************************
   // Five samples cover the two-flop synchroniser plus the flag register.
   property p_flag_set;
      low_voltage_warning [*5] ##0 s_ctl_read |=> s_axi_rdata[7];
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("flag clear under warning");
   property p_ack_zero;
      s_ctl_read |=> s_axi_rvalid && s_axi_rdata[6] == 1'b0 && s_axi_rdata[31:8] == 24'h0;
   endproperty
   a_ack_zero: assert property (p_ack_zero) else $error("ack bit reads one");
   property p_req_active;
      detect_reset_req |-> detect_active;
   endproperty
   a_req_active: assert property (p_req_active) else $error("reset without detect");
   property p_req_drop;
      !low_voltage_detect [*5] |-> !detect_reset_req;
   endproperty
   a_req_drop: assert property (p_req_drop) else $error("reset without event");
   property p_wr_answer;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid;
   endproperty
   a_wr_answer: assert property (p_wr_answer) else $error("late write answer");
   property p_rd_answer;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("late read answer");
   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
   property p_busy;
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
   endproperty
   a_busy: assert property (p_busy) else $error("ready while answer pending");

   // Main scenarios reached.
   c_flag: cover property (p_flag_set);
   c_req: cover property (detect_reset_req);
   c_stop_off: cover property ($fell(detect_active));
endmodule

bind lv_detect_control lv_detect_control_properties lv_detect_control_properties_inst (
   .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .low_voltage_warning(low_voltage_warning),
   .low_voltage_detect(low_voltage_detect), .detect_active(detect_active),
   .detect_reset_req(detect_reset_req)
);

// >>> lv_detect_control_tb.sv
// Self-checking bench for the low-voltage detect register block.
// Assumes the checker file is compiled alongside and binds itself.
`timescale 1ns/100ps
module lv_detect_control_tb;
   // ****************************************************
   // Signals
   // ****************************************************
   localparam logic [15:0] ctl = lv_pkg::status_control_addr;
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic [15:0] awaddr = 16'h0;
   logic [15:0] araddr = 16'h0;
   logic [31:0] wdata = 32'h0;
   logic        awvalid = 1'b0;
   logic        wvalid = 1'b0;
   logic        bready = 1'b0;
   logic        arvalid = 1'b0;
   logic        rready = 1'b0;
   logic        low_voltage_warning = 1'b0;
   logic        low_voltage_detect = 1'b0;
   logic        stop_mode = 1'b0;
   logic        debug_mode_enable = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid, detect_active, detect_reset_req, irq;
   logic [1:0]  bresp, rresp, resp;
   logic [31:0] rdata, d;
   int          n_fail = 0;
   int          samples_checked = 0;

   always #20 aclk = ~aclk;

   // All byte lanes are always enabled; partial writes are not exercised.
   lv_detect_control lv_detect_control_inst (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .low_voltage_warning(low_voltage_warning), .low_voltage_detect(low_voltage_detect),
      .stop_mode(stop_mode), .debug_mode_enable(debug_mode_enable),
      .detect_active(detect_active), .detect_reset_req(detect_reset_req), .irq(irq)
   );

   // ****************************************************
   // Tasks
   // ****************************************************
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic test_done;
      if (n_fail == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge aclk);
   endtask

   // Handshakes are sampled at the falling edge, where nothing moves, and acted on
   // right after the next rising edge, so no race with the design's flops arises.
   task automatic wr(input logic [15:0] a, input logic [31:0] v);
      int   n;
      logic ah, wh, bh;
      n = 0;
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(negedge aclk);
         ah = awvalid && awready;
         wh = wvalid && wready;
         bh = bvalid;
         resp = bresp;
         @(posedge aclk);
         if (ah) awvalid <= 1'b0;
         if (wh) wvalid <= 1'b0;
         n++;
      end while (!bh && n < 50);
      bready <= 1'b0;
      if (!bh) begin
         n_fail++;
         test_done();
      end
      tick(1); // An idle edge keeps the next call from retoggling bready.
   endtask

   task automatic rd(input logic [15:0] a, output logic [31:0] v);
      int   n;
      logic ah, rh;
      n = 0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(negedge aclk);
         ah = arvalid && arready;
         rh = rvalid;
         v = rdata;
         resp = rresp;
         @(posedge aclk);
         if (ah) arvalid <= 1'b0;
         n++;
      end while (!rh && n < 50);
      rready <= 1'b0;
      if (!rh) begin
         n_fail++;
         test_done();
      end
      tick(1); // An idle edge keeps the next call from retoggling rready.
   endtask

   task automatic rdc(input string what, input logic [15:0] a, input logic [31:0] e);
      rd(a, d);
      chk(what, d, e);
   endtask

   // ****************************************************
   // Main sequence
   // ****************************************************
   initial begin
      tick(6);
      aresetn <= 1'b1;
      tick(2);
      rdc("ctl reset", ctl, 32'h1c);
      chk("ctl resp", {30'h0, resp}, {30'h0, lv_pkg::resp_okay});
      rd(16'h3050, d);
      chk("hole read", {30'h0, resp}, {30'h0, lv_pkg::resp_slverr});
      wr(16'h3050, 32'h0);
      chk("hole write", {30'h0, resp}, {30'h0, lv_pkg::resp_slverr});
      low_voltage_warning <= 1'b1;
      tick(4);
      rdc("flag set", ctl, 32'h9c);
      wr(ctl, 32'h5c);
      rdc("ack refused", ctl, 32'h9c);
      low_voltage_warning <= 1'b0;
      tick(4);
      rdc("flag sticky", ctl, 32'h9c);
      wr(ctl, 32'h5c);
      rdc("ack taken", ctl, 32'h1c);
      wr(ctl, 32'h00);
      rdc("locked bits", ctl, 32'h14);
      chk("active", {31'h0, detect_active}, 32'h1);
      stop_mode <= 1'b1;
      tick(4);
      chk("stop off", {31'h0, detect_active}, 32'h0);
      debug_mode_enable <= 1'b1;
      tick(4);
      chk("debug on", {31'h0, detect_active}, 32'h1);
      debug_mode_enable <= 1'b0;
      wr(ctl, 32'h1c);
      tick(4);
      chk("stop on", {31'h0, detect_active}, 32'h1);
      stop_mode <= 1'b0;
      low_voltage_detect <= 1'b1;
      tick(4);
      chk("reset req", {31'h0, detect_reset_req}, 32'h1);
      low_voltage_detect <= 1'b0;
      wr(ctl, 32'h3c);
      tick(2);
      chk("irq idle", {31'h0, irq}, 32'h0);
      low_voltage_warning <= 1'b1;
      tick(4);
      chk("irq up", {31'h0, irq}, 32'h1);
      wr(ctl, 32'h1c);
      tick(2);
      chk("irq off", {31'h0, irq}, 32'h0);
      wr(ctl, 32'h3c);
      low_voltage_warning <= 1'b0;
      tick(4);
      wr(ctl, 32'h7c);
      tick(2);
      chk("irq acked", {31'h0, irq}, 32'h0);
      wr(ctl, 32'h1c);
      // Both events were seen above, so both status bits stand pending.
      wr(lv_pkg::irq_mask_addr, 32'h1);
      rdc("events", lv_pkg::irq_status_addr, 32'h3);
      chk("evt irq", {31'h0, irq}, 32'h1);
      wr(lv_pkg::irq_status_addr, 32'h3);
      rdc("events clr", lv_pkg::irq_status_addr, 32'h0);
      chk("evt clr", {31'h0, irq}, 32'h0);
      low_voltage_warning <= 1'b1;
      tick(4);
      chk("evt again", {31'h0, irq}, 32'h1);
      wr(lv_pkg::irq_mask_addr, 32'h0);
      tick(2);
      chk("evt masked", {31'h0, irq}, 32'h0);
      // A second reset with the supply already low re-arms the write-once bits.
      aresetn <= 1'b0;
      tick(2);
      aresetn <= 1'b1;
      tick(4);
      rdc("flag at reset", ctl, 32'h9c);
      wr(ctl, 32'h00);
      rdc("disabled", ctl, 32'h80);
      low_voltage_detect <= 1'b1;
      tick(4);
      chk("off active", {31'h0, detect_active}, 32'h0);
      chk("off req", {31'h0, detect_reset_req}, 32'h0);
      rdc("levels", lv_pkg::line_status_addr, 32'h3);
      wr(ctl, 32'h14);
      rdc("still locked", ctl, 32'h80);
      test_done();
   end
endmodule
